// >>> src/ctrl_state_regs.sv
// controller state registers set by decoded commands
// assumes one-cycle command strobes from the host port
`timescale 1ns/1ps
`include "host_port_params.svh"
module ctrl_state_regs (
	input  wire logic       core_clk_in,
	input  wire logic       rst_n_in,
	input  wire logic       cmd_valid_in,
	input  wire logic [7:0] cmd_byte_in,
	input  wire logic       data_valid_in,
	input  wire logic [7:0] data_byte_in,
	output logic            display_on_out,
	output logic            cursor_on_out,
	output logic            blink_on_out,
	output logic [7:0]      contrast_out,
	output logic [6:0]      ram_addr_out,
	output logic [7:0]      status_out
);
	typedef struct packed {
		logic       disp;
		logic       cur;
		logic       blk;
		logic       ext;
		logic       tall;
		logic       want_contrast;
		logic [7:0] contrast;
		logic [6:0] addr;
		logic [5:0] cg_addr;
	} st_type;
	st_type st_q;
	st_type st_d;
	// tiny subset: display control, set address, contrast via extended pair
	always_comb begin
		st_d = st_q;
		if (cmd_valid_in) begin
			if (st_q.want_contrast) begin
				st_d.contrast      = cmd_byte_in;
				st_d.want_contrast = 1'b0;
			end else if (cmd_byte_in[7]) begin
				st_d.addr = cmd_byte_in[6:0];
			end else if (cmd_byte_in[7:6] == 2'b01) begin
				st_d.cg_addr = cmd_byte_in[5:0];
			end else if (cmd_byte_in[7:3] == 5'b00001) begin
				st_d.disp = cmd_byte_in[2];
				st_d.cur  = cmd_byte_in[1];
				st_d.blk  = cmd_byte_in[0];
			end else if (cmd_byte_in[7:5] == 3'b001) begin
				st_d.ext  = cmd_byte_in[1];
				st_d.tall = cmd_byte_in[2];
			end else if (cmd_byte_in == 8'h01 && st_q.ext) begin
				st_d.want_contrast = 1'b1; // next command byte is the level
			end
		end
		if (data_valid_in) begin
			st_d.addr = st_q.addr + 7'h01; // data writes advance the counter
		end
	end
	// reset image: display off, 5x8, counters zero, cursor and blink off
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_q <= '{disp: 1'b0, cur: 1'b0, blk: 1'b0, ext: 1'b0, tall: 1'b0,
				want_contrast: 1'b0, contrast: `CONTRAST_RESET,
				addr: 7'h00, cg_addr: 6'h00};
		end else begin
			st_q <= st_d;
		end
	end
	assign display_on_out = st_q.disp;
	assign cursor_on_out  = st_q.cur;
	assign blink_on_out   = st_q.blk;
	assign contrast_out   = st_q.contrast;
	assign ram_addr_out   = st_q.addr;
	assign status_out     = {1'b0, st_q.addr};
	wire unused_ok = ^{data_byte_in, st_q.tall, st_q.cg_addr};
endmodule

// >>> src/display_host_interface_port.sv
// host side port: parallel, serial or i2c onto shared data pins
// assumes all pin inputs synchronous to core_clk_in; mode pins static
`timescale 1ns/1ps
`include "host_port_params.svh"
module display_host_interface_port #(
	parameter logic [6:0] I2C_ADDR = `I2C_ADDR_DEFAULT
) (
	input  wire logic       core_clk_in,
	input  wire logic       rst_n_in,
	input  wire logic [2:0] link_mode_in,
	input  wire logic       chip_sel_n_in,
	input  wire logic       data_cmd_in,
	input  wire logic       strobe_in,
	input  wire logic       dir_in,
	input  wire logic [7:0] host_data_lines_in,
	output logic      [7:0] host_data_lines_out,
	output logic      [7:0] host_data_lines_oe_n_out,
	output logic            cmd_valid_out,
	output logic            data_valid_out,
	output logic      [7:0] byte_out,
	output logic            display_on_out,
	output logic            cursor_on_out,
	output logic            blink_on_out,
	output logic      [7:0] contrast_out,
	output logic      [6:0] ram_addr_out
);
	typedef struct packed {
		logic                       strobe;
		logic                       dir;
		logic                       sclk;
		logic                       sda;
		logic [7:0]                 shift;
		logic [2:0]                 cnt;
		host_port_pkg::i2c_state_type i2c;
		logic                       i2c_dc;
		logic                       i2c_full;
		logic                       i2c_ctl;
		logic                       ack_drive;
		logic                       rd_drive;
		logic [7:0]                 rd_byte;
		logic                       cmd_v;
		logic                       dat_v;
		logic [7:0]                 byte_q;
	} st_type;
	st_type st_q;
	st_type st_d;
	logic [7:0] status_w;
	logic       sclk_w;
	logic       sda_w;
	logic       sclk_rise;
	logic       sclk_fall;
	logic       is_sep;
	logic       is_par;
	logic       rd_on;
	logic       wr_ev;

	// one more bit into the shift register, msb first on every serial link
	function automatic logic [7:0] shift_in(input logic [7:0] cur, input logic bit_in);
		return {cur[6:0], bit_in};
	endfunction

	// i2c data arrives on pin one; pin two is tied to it outside
	assign sclk_w    = host_data_lines_in[`PIN_SCLK];
	assign sda_w     = host_data_lines_in[`PIN_SERIAL_DATA_IN];
	assign sclk_rise = sclk_w && !st_q.sclk;
	assign sclk_fall = !sclk_w && st_q.sclk;
	assign is_sep    = link_mode_in == `MODE_PAR_SEPARATE;
	assign is_par    = is_sep || link_mode_in == `MODE_PAR_ENABLE;
	// read window: enable style needs strobe high with dir high, separate needs strobe low
	assign rd_on = is_par && !chip_sel_n_in &&
		(is_sep ? !strobe_in : (strobe_in && dir_in));
	// write events: falling strobe in enable style, falling write strobe in separate
	assign wr_ev = is_par && !chip_sel_n_in &&
		(is_sep ? (!dir_in && st_q.dir)
			: (!strobe_in && st_q.strobe && !dir_in));
	////////////////////////////////////////////////////////////////////////
	// i2c frame as the port sees it:
	//   start, then the address byte with its write bit, acked by pulling pin two low
	//   the first byte after the address is a control byte, never handed on
	//   its bit six picks data or command for every later byte of the frame
	//   a foreign address leaves the port silent until the next start
	// limitation: the continuation bit is ignored, so one frame carries one kind
	// a byte is only complete after eight rises; a 3-bit count alone cannot
	// tell "no bits yet" from "eight bits", hence the separate full flag

	// next state for every link
	always_comb begin
		st_d          = st_q;
		st_d.strobe   = strobe_in;
		st_d.dir      = dir_in;
		st_d.sclk     = sclk_w;
		st_d.sda      = sda_w;
		st_d.cmd_v    = 1'b0;
		st_d.dat_v    = 1'b0;
		st_d.rd_drive = rd_on;
		if (rd_on && !st_q.rd_drive) begin
			st_d.rd_byte = status_w; // captured at start so it stands stable
		end
		case (link_mode_in)
			// parallel styles: one byte per strobe edge, read data from the latch
			`MODE_PAR_ENABLE, `MODE_PAR_SEPARATE: begin
				if (wr_ev) begin
					st_d.byte_q = host_data_lines_in;
					st_d.dat_v  = data_cmd_in;
					st_d.cmd_v  = !data_cmd_in;
				end
			end
			// clocked serial: eight rises make a byte, deselect drops a partial one
			`MODE_SERIAL: begin
				if (chip_sel_n_in) begin
					st_d.cnt = 3'h0; // deselect realigns the byte
				end else if (sclk_rise) begin
					st_d.shift = shift_in(st_q.shift, sda_w);
					st_d.cnt   = st_q.cnt + 3'h1;
					if (st_q.cnt == `SER_BIT_COUNT) begin
						st_d.byte_q = shift_in(st_q.shift, sda_w);
						st_d.dat_v  = data_cmd_in;
						st_d.cmd_v  = !data_cmd_in;
					end
				end
			end
			// i2c: start and stop seen while the clock is high, bits on rises
			`MODE_I2C: begin
				if (st_q.sclk && sclk_w && st_q.sda && !sda_w) begin
					st_d.i2c      = host_port_pkg::i2c_addr; // start
					st_d.cnt      = 3'h0;
					st_d.i2c_full = 1'b0;
					st_d.i2c_ctl  = 1'b0; // a control byte leads every frame
				end else if (st_q.sclk && sclk_w && !st_q.sda && sda_w) begin
					st_d.i2c       = host_port_pkg::i2c_idle; // stop
					st_d.ack_drive = 1'b0;
				end else if (sclk_rise && st_q.i2c != host_port_pkg::i2c_idle) begin
					st_d.shift = shift_in(st_q.shift, sda_w);
					st_d.cnt   = st_q.cnt + 3'h1;
					if (st_q.cnt == `SER_BIT_COUNT) begin
						st_d.i2c_full = 1'b1; // eighth bit in, acted on at the next fall
					end
				end else if (sclk_fall) begin
					st_d.ack_drive = 1'b0;
					if (st_q.i2c_full && st_q.i2c == host_port_pkg::i2c_addr) begin
						st_d.i2c_full = 1'b0;
						if (st_q.shift[7:1] == I2C_ADDR && !st_q.shift[0]) begin
							st_d.ack_drive = 1'b1;
							st_d.i2c       = host_port_pkg::i2c_ack;
						end else begin
							st_d.i2c = host_port_pkg::i2c_skip;
						end
					end else if (st_q.i2c == host_port_pkg::i2c_ack) begin
						st_d.i2c = host_port_pkg::i2c_data;
						st_d.cnt = 3'h0;
					end else if (st_q.i2c_full && st_q.i2c == host_port_pkg::i2c_data) begin
						st_d.i2c_full  = 1'b0;
						st_d.ack_drive = 1'b1;
						st_d.i2c       = host_port_pkg::i2c_ack;
						if (st_q.i2c_ctl) begin
							st_d.byte_q = st_q.shift;
							st_d.dat_v  = st_q.i2c_dc;
							st_d.cmd_v  = !st_q.i2c_dc;
						end else begin
							// control byte: remembered, not passed on
							st_d.i2c_dc  = st_q.shift[`I2C_DC_BIT];
							st_d.i2c_ctl = 1'b1;
						end
					end
				end
			end
			default: begin
				st_d.i2c = host_port_pkg::i2c_idle;
			end
		endcase
	end
	// reset clears all transfer state
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end
	////////////////////////////////////////////////////////////////////////
	// pin drive: oe low means driving; i2c ack pulls pin two low
	always_comb begin
		host_data_lines_out      = st_q.rd_byte;
		host_data_lines_oe_n_out = {8{!st_q.rd_drive}};
		if (link_mode_in == `MODE_I2C) begin
			host_data_lines_out = `ZERO_BYTE;
			host_data_lines_oe_n_out = 8'hff;
			host_data_lines_oe_n_out[`PIN_SDA_OUT] = !st_q.ack_drive;
		end
	end
	assign cmd_valid_out  = st_q.cmd_v;
	assign data_valid_out = st_q.dat_v;
	assign byte_out       = st_q.byte_q;

	////////////////////////////////////////////////////////////////////////
	// reserved i2c address ranges would clash with general call and long addressing
	if (I2C_ADDR[6:3] == 4'h0 || I2C_ADDR[6:3] == 4'hf) begin : g_addr_check
		$error("port address parameter lies in a reserved range");
	end

	// controller state behind the port; it also supplies the read-back byte
	ctrl_state_regs u_regs (
		.core_clk_in    (core_clk_in),
		.rst_n_in       (rst_n_in),
		.cmd_valid_in   (st_q.cmd_v),
		.cmd_byte_in    (st_q.byte_q),
		.data_valid_in  (st_q.dat_v),
		.data_byte_in   (st_q.byte_q),
		.display_on_out (display_on_out),
		.cursor_on_out  (cursor_on_out),
		.blink_on_out   (blink_on_out),
		.contrast_out   (contrast_out),
		.ram_addr_out   (ram_addr_out),
		.status_out     (status_w)
	);
endmodule

// >>> src/host_port_params.svh
// constants for the display host interface port
// assumes inclusion by the package and the port modules
`ifndef HOST_PORT_PARAMS_SVH
`define HOST_PORT_PARAMS_SVH
`define CONTRAST_RESET    8'h7f
`define ZERO_BYTE         8'h00
`define SER_BIT_COUNT     3'h7
`define I2C_ADDR_DEFAULT  7'h3c
`define MODE_I2C          3'h0
`define MODE_SERIAL       3'h1
`define MODE_PAR_ENABLE   3'h2
`define MODE_PAR_SEPARATE 3'h3
`define PIN_SCLK          0
`define PIN_SERIAL_DATA_IN          1
`define PIN_SDA_OUT       2
`define I2C_DC_BIT        6
`endif

// >>> src/host_port_pkg.sv
// types shared by the host interface port
// assumes the params header is on the include path
`include "host_port_params.svh"
package host_port_pkg;
	typedef enum logic [2:0] {
		link_i2c          = 3'h0,
		link_serial       = 3'h1,
		link_par_enable   = 3'h2,
		link_par_separate = 3'h3
	} link_mode_type;
	typedef enum logic [2:0] {
		i2c_idle = 3'h0,
		i2c_addr = 3'h1,
		i2c_ack  = 3'h2,
		i2c_data = 3'h3,
		i2c_skip = 3'h4
	} i2c_state_type;
endpackage

// >>> verification/display_host_interface_port_tb_top.sv
// self-checking bench for the display host port
// assumes the host model drives every pin and the checker is bound in
`timescale 1ns/1ps
module display_host_interface_port_tb_top;
	logic       core_clk_in, rst_n_in, chip_sel_n_in, data_cmd_in, strobe_in, dir_in, drv_en;
	logic       cmd_valid_out, data_valid_out, display_on_out, cursor_on_out, blink_on_out;
	logic [2:0] link_mode_in, ack;
	logic [7:0] host_data_lines_in, host_data_lines_out, host_data_lines_oe_n_out;
	logic [7:0] byte_out, contrast_out, drv, b, rb, host_lvl;
	logic       sda_line;
	logic [6:0] ram_addr_out, exp_addr;
	int         num_errors, check_count, n_cmd, n_dat, e_cmd, e_dat, seed;
	// released parallel pins show the inverse of the last value; i2c lines have pull-ups
	assign host_lvl = drv_en ? drv : ~drv;
	// i2c data is one wire on pins one and two: host and ack both pull it low
	assign sda_line = (drv_en ? drv[1] : 1'b1)
		& (host_data_lines_oe_n_out[2] | host_data_lines_out[2]);
	// each pin resolves to the device where it drives, else to the host
	assign host_data_lines_in = (link_mode_in == 3'h0)
		? {host_lvl[7:3], sda_line, sda_line, drv_en ? drv[0] : 1'b1}
		: ((~host_data_lines_oe_n_out & host_data_lines_out)
		| (host_data_lines_oe_n_out & host_lvl));
	display_host_interface_port uut (.core_clk_in, .rst_n_in, .link_mode_in, .chip_sel_n_in,
		.data_cmd_in, .strobe_in, .dir_in, .host_data_lines_in, .host_data_lines_out,
		.host_data_lines_oe_n_out, .cmd_valid_out, .data_valid_out, .byte_out,
		.display_on_out, .cursor_on_out, .blink_on_out, .contrast_out, .ram_addr_out);
	host_mcu_model host (.core_clk_in, .bus_in(host_data_lines_in), .mode_out(link_mode_in),
		.cs_n_out(chip_sel_n_in), .dc_out(data_cmd_in), .stb_out(strobe_in), .dir_out(dir_in),
		.drv_out(drv), .drv_en_out(drv_en));
	initial begin
		core_clk_in = 1'b0;
		forever #25 core_clk_in = ~core_clk_in;
	end
	// pulses are counted here so none is missed between compares
	always @(posedge core_clk_in) begin
		if (cmd_valid_out === 1'b1) n_cmd++;
		if (data_valid_out === 1'b1) n_dat++;
	end
	////////////////////////////////////////////////////////////////
	task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			$display("unexpected %s expected %h seen %h", s, e, g);
			num_errors++;
		end
	endtask
	function automatic logic [7:0] flags();
		return {5'h00, display_on_out, cursor_on_out, blink_on_out};
	endfunction
	task automatic xfer(input logic [2:0] m, input logic dc, input logic [7:0] d);
		if (m == 3'h0) host.iic({8'h78, (dc ? 8'h40 : 8'h00), d}, ack);
		else if (m == 3'h1) host.ser(dc, d);
		else host.wr(m, 1'b0, dc, d);
		host.step(3);
		if (m == 3'h0) chk("i2c acks", 8'h00, {5'h00, ack});
		if (dc) e_dat++;
		else e_cmd++;
		if (dc) exp_addr++;
		chk("byte_out", d, byte_out);
		chk("data pulses", 8'(e_dat), 8'(n_dat));
		chk("command pulses", 8'(e_cmd), 8'(n_cmd));
	endtask
	task automatic results();
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial begin
		#500000;
		num_errors++;
		results();
	end
	initial begin
		seed = 19658;
		rst_n_in = 1'b0;
		repeat (6) @(posedge core_clk_in);
		#2 rst_n_in = 1'b1;
		chk("contrast", 8'h7f, contrast_out);
		chk("flags", 8'h00, flags());
		chk("address", 8'h00, {1'b0, ram_addr_out});
		// random address, then random data alternating between parallel styles
		exp_addr = 7'($random(seed));
		xfer(3'h2, 1'b0, {1'b1, exp_addr});
		for (int i = 0; i < 12; i++) begin
			b = 8'($random(seed));
			xfer(i[0] ? 3'h3 : 3'h2, 1'b1, b);
			chk("address", {1'b0, exp_addr}, {1'b0, ram_addr_out});
		end
		for (int m = 2; m < 4; m++) begin
			host.rd(3'(m), rb);
			chk("read data", {1'b0, exp_addr}, rb);
			host.step(2);
		end
		// deselected write must leave no trace
		host.wr(3'h3, 1'b1, 1'b1, 8'h3c);
		host.step(3);
		chk("data pulses", 8'(e_dat), 8'(n_dat));
		xfer(3'h2, 1'b0, 8'h0f);
		chk("flags", 8'h07, flags());
		xfer(3'h3, 1'b0, 8'h0c);
		chk("flags", 8'h04, flags());
		b = 8'($random(seed));
		xfer(3'h1, 1'b1, b);
		xfer(3'h1, 1'b0, 8'h08);
		chk("flags", 8'h00, flags());
		b = 8'($random(seed));
		xfer(3'h2, 1'b0, 8'h2a);
		xfer(3'h2, 1'b0, 8'h01);
		xfer(3'h3, 1'b0, b);
		chk("contrast", b, contrast_out);
		// i2c frames: a command, a data byte, then one to a foreign address
		xfer(3'h0, 1'b0, 8'h0f);
		chk("flags", 8'h07, flags());
		b = 8'($random(seed));
		xfer(3'h0, 1'b1, b);
		chk("address", {1'b0, exp_addr}, {1'b0, ram_addr_out});
		host.iic({8'h7a, 8'h00, 8'h0c}, ack);
		host.step(3);
		chk("i2c acks", 8'h07, {5'h00, ack});
		chk("flags", 8'h07, flags());
		chk("command pulses", 8'(e_cmd), 8'(n_cmd));
		// second reset in mid-run restores the defined state
		rst_n_in = 1'b0;
		host.step(2);
		rst_n_in = 1'b1;
		chk("contrast", 8'h7f, contrast_out);
		chk("address", 8'h00, {1'b0, ram_addr_out});
		results();
	end
endmodule

// >>> verification/host_mcu_model.sv
// host microcontroller model: parallel writes and reads, serial bytes
// assumes the bench resolves the shared pins into bus_in
`timescale 1ns/1ps
module host_mcu_model (
	input  wire logic       core_clk_in,
	input  wire logic [7:0] bus_in,
	output logic      [2:0] mode_out,
	output logic            cs_n_out,
	output logic            dc_out,
	output logic            stb_out,
	output logic            dir_out,
	output logic      [7:0] drv_out,
	output logic            drv_en_out
);
	initial begin
		mode_out = 3'h2;
		{cs_n_out, dc_out, stb_out, dir_out, drv_out, drv_en_out} = {1'b1, 11'h000};
	end
	////////////////////////////////////////////////////////////////
	// pins change just after an edge; strobe edges kept two cycles apart
	task automatic step(input int n);
		repeat (n) @(posedge core_clk_in);
		#2;
	endtask
	task automatic idle(input logic [2:0] m);
		cs_n_out = 1'b1;
		stb_out = (m == 3'h3);
		dir_out = (m == 3'h3);
		drv_en_out = 1'b0; // released pins show the inverse of the last value
	endtask
	task automatic wr(input logic [2:0] m, input logic sel_n, input logic dc, input logic [7:0] d);
		mode_out = m;
		cs_n_out = sel_n;
		dc_out = dc;
		drv_out = d;
		drv_en_out = 1'b1;
		stb_out = 1'b1;
		dir_out = (m == 3'h3);
		step(2);
		if (m == 3'h2) stb_out = 1'b0;
		else dir_out = 1'b0;
		step(2);
		idle(m);
	endtask
	task automatic rd(input logic [2:0] m, output logic [7:0] d);
		mode_out = m;
		cs_n_out = 1'b0;
		drv_en_out = 1'b0;
		dir_out = 1'b1;
		stb_out = (m == 3'h2);
		step(4);
		d = bus_in;
		idle(m);
	endtask
	// serial clock on pin zero is driven low at both ends of a frame, msb first
	task automatic ser(input logic dc, input logic [7:0] d);
		mode_out = 3'h1;
		cs_n_out = 1'b0;
		dc_out = dc;
		drv_en_out = 1'b1;
		for (int i = 7; i >= 0; i--) begin
			drv_out = {6'h00, d[i], 1'b0};
			step(2);
			drv_out[0] = 1'b1;
			step(2);
		end
		drv_out[0] = 1'b0;
		step(2);
		idle(3'h1);
	endtask
	// i2c frame: start, three bytes msb first each with an ack clock, stop;
	// the host drives ones to let the data line float up to its pull-up
	task automatic iic(input logic [23:0] f, output logic [2:0] ack);
		mode_out = 3'h0;
		cs_n_out = 1'b0; // select is tied active on an i2c link
		drv_en_out = 1'b1;
		drv_out = 8'h03; // clock and data both high before the start
		step(2);
		drv_out[1] = 1'b0; // start: data falls while the clock is high
		step(2);
		for (int i = 23; i >= 0; i--) begin
			drv_out = {6'h00, f[i], 1'b0};
			step(2);
			drv_out[0] = 1'b1;
			step(2);
			if (i % 8 == 0) begin
				drv_out = 8'h02; // data let go for the ack clock
				step(2);
				drv_out[0] = 1'b1;
				step(1);
				ack[i / 8] = bus_in[1];
				step(1);
			end
		end
		drv_out = 8'h00;
		step(2);
		drv_out[0] = 1'b1;
		step(2);
		drv_out[1] = 1'b1; // stop: data rises while the clock is high
		step(2);
		drv_en_out = 1'b0;
		cs_n_out = 1'b1;
	endtask
endmodule

// >>> verification/host_port_monitor.sv
// checker on the host port pins and the decoded strobes and state
// assumes it is bound into the port module and sees its ports only
`timescale 1ns/1ps
module host_port_monitor (
	input wire logic       core_clk_in,
	input wire logic       rst_n_in,
	input wire logic [2:0] link_mode_in,
	input wire logic       chip_sel_n_in,
	input wire logic       data_cmd_in,
	input wire logic       strobe_in,
	input wire logic       dir_in,
	input wire logic [7:0] host_data_lines_out,
	input wire logic [7:0] host_data_lines_oe_n_out,
	input wire logic       cmd_valid_out,
	input wire logic       data_valid_out,
	input wire logic       display_on_out,
	input wire logic [7:0] contrast_out,
	input wire logic [6:0] ram_addr_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);
	logic rd_win;
	// read window in either parallel style; i2c left out since its ack drives a pin
	assign rd_win = !chip_sel_n_in && dir_in
		&& ((link_mode_in == 3'h2 && strobe_in) || (link_mode_in == 3'h3 && !strobe_in));
	////////////////////////////////////////////////////////////////
	a_reset_state: assert property (
		$rose(rst_n_in) |-> contrast_out == 8'h7f && !display_on_out && ram_addr_out == 7'h00)
		else $error("state after reset wrong");
	a_enable_cmd: assert property (
		link_mode_in == 3'h2 && !chip_sel_n_in && !dir_in && !data_cmd_in && $fell(strobe_in)
		|-> ##[1:3] cmd_valid_out) else $error("enable style command not taken");
	a_separate_data: assert property (
		link_mode_in == 3'h3 && !chip_sel_n_in && data_cmd_in && $fell(dir_in)
		|-> ##[1:3] data_valid_out) else $error("separate style data not taken");
	a_select_refuse: assert property (
		chip_sel_n_in [*4] |-> !cmd_valid_out && !data_valid_out)
		else $error("transfer taken while deselected");
	a_pulse_single: assert property (
		cmd_valid_out || data_valid_out |=> !cmd_valid_out && !data_valid_out)
		else $error("valid pulse too long");
	a_kind_exclusive: assert property (
		!(cmd_valid_out && data_valid_out)) else $error("command and data together");
	a_read_drive: assert property (
		rd_win [*4] |-> host_data_lines_oe_n_out == 8'h00
		&& host_data_lines_out == {1'b0, ram_addr_out}) else $error("read not driven");
	a_release_bus: assert property (
		(!rd_win && link_mode_in != 3'h0) [*3] |-> host_data_lines_oe_n_out == 8'hff)
		else $error("pins driven outside read");
	a_i2c_pins: assert property (
		link_mode_in == 3'h0 |-> host_data_lines_oe_n_out[7:3] == 5'h1f
		&& host_data_lines_oe_n_out[1:0] == 2'h3) else $error("i2c drives a pin besides the ack pin");
	c_data: cover property (data_valid_out);
	c_i2c_ack: cover property (link_mode_in == 3'h0 && !host_data_lines_oe_n_out[2]);
	c_cmd: cover property (cmd_valid_out);
	c_read: cover property (rd_win [*4]);
endmodule
bind display_host_interface_port host_port_monitor monitor (
	.core_clk_in, .rst_n_in, .link_mode_in, .chip_sel_n_in, .data_cmd_in, .strobe_in,
	.dir_in, .host_data_lines_out, .host_data_lines_oe_n_out, .cmd_valid_out,
	.data_valid_out, .display_on_out, .contrast_out, .ram_addr_out);
